/* File: rtl/pal_pkg.sv */
// Shared types, encodings and latency table of the peripheral access latency bridge
package pal_pkg;

    // Access width
    typedef enum logic [1:0] {
        PAL_SZ_BYTE = 2'b00,
        PAL_SZ_HALF = 2'b01,
        PAL_SZ_WORD = 2'b10
    } pal_size_e;

    // Clock that a region's cycle counts are given in
    typedef enum logic [1:0] {
        PAL_DOM_CORE = 2'b00,
        PAL_DOM_FAST = 2'b01,
        PAL_DOM_SLOW = 2'b10,
        PAL_DOM_FLASH = 2'b11
    } pal_dom_e;

    // Upstream request from the core bus master
    typedef struct packed {
        logic [31:0] addr;
        logic write;
        pal_size_e size;
        logic [31:0] wdata;
    } pal_req_s;

    // Upstream answer
    typedef struct packed {
        logic done;
        logic err;
        logic [31:0] rdata;
    } pal_rsp_s;

    // Downstream access to the peripheral register blocks
    typedef struct packed {
        logic req;
        logic [31:0] addr;
        logic write;
        pal_size_e size;
        logic [31:0] wdata;
    } pal_per_s;

    // One latency table row; counts are in cycles of the row's clock
    typedef struct packed {
        logic [31:0] lo;
        logic [31:0] hi;
        pal_dom_e dom;
        logic [4:0] rd_eq;
        logic [4:0] wr_eq;
        logic [4:0] rd_min;
        logic [4:0] rd_max;
        logic [4:0] wr_min;
        logic [4:0] wr_max;
        logic rd_open;
        logic wr_open;
    } pal_region_s;

    localparam int PAL_NREG = 25;
    localparam logic [4:0] PAL_REG_SYS = 5'h00;
    localparam logic [4:0] PAL_REG_SCI = 5'h0f;
    localparam logic [4:0] PAL_REG_SPI = 5'h10;
    localparam logic [4:0] PAL_REG_CONV = 5'h13;
    localparam logic [4:0] PAL_REG_QCTL = 5'h15;
    localparam logic [5:0] PAL_WIDTH_EXTRA = 6'h02;
    localparam logic [9:0] PAL_UNMAPPED_LAT = 10'h002;
    localparam logic [3:0] PAL_DIV_EQUAL = 4'h1;
    localparam logic [9:0] PAL_CNT_RST = 10'h000;

    // Earlier rows win where ranges overlap; fractional figures are already
    // truncated (least) and rounded up (most) in the min and max columns
    localparam pal_region_s PAL_TABLE [PAL_NREG] = '{
        '{32'h4000_0000, 32'h4000_6fff, PAL_DOM_CORE,
          5'h02, 5'h02, 5'h02, 5'h02, 5'h02, 5'h02, 1'b0, 1'b0},
        '{32'h4000_8000, 32'h4001_cfff, PAL_DOM_CORE,
          5'h04, 5'h03, 5'h04, 5'h04, 5'h03, 5'h03, 1'b0, 1'b0},
        '{32'h4001_e000, 32'h4001_e3ff, PAL_DOM_CORE,
          5'h05, 5'h04, 5'h05, 5'h05, 5'h04, 5'h04, 1'b0, 1'b0},
        '{32'h4001_e400, 32'h4001_e5ff, PAL_DOM_SLOW,
          5'h09, 5'h08, 5'h05, 5'h08, 5'h05, 5'h08, 1'b0, 1'b0},
        '{32'h4008_0000, 32'h4008_0fff, PAL_DOM_SLOW,
          5'h05, 5'h04, 5'h02, 5'h05, 5'h02, 5'h04, 1'b0, 1'b0},
        '{32'h4008_2000, 32'h4008_3fff, PAL_DOM_SLOW,
          5'h05, 5'h04, 5'h03, 5'h05, 5'h02, 5'h04, 1'b0, 1'b0},
        '{32'h4008_4000, 32'h4008_4fff, PAL_DOM_SLOW,
          5'h05, 5'h04, 5'h02, 5'h05, 5'h02, 5'h04, 1'b0, 1'b0},
        '{32'h4008_a000, 32'h4008_afff, PAL_DOM_SLOW,
          5'h05, 5'h04, 5'h03, 5'h05, 5'h02, 5'h04, 1'b0, 1'b0},
        '{32'h4009_0000, 32'h4009_3fff, PAL_DOM_SLOW,
          5'h06, 5'h05, 5'h03, 5'h06, 5'h03, 5'h05, 1'b0, 1'b0},
        '{32'h4009_4000, 32'h4009_4fff, PAL_DOM_SLOW,
          5'h04, 5'h03, 5'h01, 5'h04, 5'h01, 5'h03, 1'b0, 1'b0},
        '{32'h4009_2000, 32'h4009_ffff, PAL_DOM_SLOW,
          5'h05, 5'h04, 5'h02, 5'h05, 5'h02, 5'h04, 1'b0, 1'b0},
        '{32'h400a_8000, 32'h400a_9fff, PAL_DOM_SLOW,
          5'h05, 5'h04, 5'h02, 5'h05, 5'h02, 5'h04, 1'b0, 1'b0},
        '{32'h400e_0000, 32'h400e_0fff, PAL_DOM_SLOW,
          5'h05, 5'h04, 5'h02, 5'h05, 5'h02, 5'h04, 1'b0, 1'b0},
        '{32'h400e_8000, 32'h400e_8fff, PAL_DOM_SLOW,
          5'h07, 5'h04, 5'h05, 5'h07, 5'h02, 5'h04, 1'b0, 1'b0},
        '{32'h4010_8000, 32'h4010_9fff, PAL_DOM_FAST,
          5'h05, 5'h04, 5'h02, 5'h05, 5'h02, 5'h04, 1'b0, 1'b0},
        '{32'h4011_8000, 32'h4011_8fff, PAL_DOM_FAST,
          5'h05, 5'h04, 5'h02, 5'h05, 5'h02, 5'h04, 1'b0, 1'b0},
        '{32'h4011_a000, 32'h4011_afff, PAL_DOM_FAST,
          5'h05, 5'h04, 5'h02, 5'h05, 5'h02, 5'h04, 1'b0, 1'b0},
        '{32'h4016_1000, 32'h4016_1fff, PAL_DOM_FAST,
          5'h06, 5'h04, 5'h03, 5'h06, 5'h02, 5'h04, 1'b0, 1'b0},
        '{32'h4016_9000, 32'h4016_9fff, PAL_DOM_FAST,
          5'h07, 5'h04, 5'h04, 5'h07, 5'h02, 5'h04, 1'b0, 1'b0},
        '{32'h4017_0000, 32'h4017_2fff, PAL_DOM_FAST,
          5'h05, 5'h04, 5'h02, 5'h05, 5'h02, 5'h04, 1'b0, 1'b0},
        '{32'h6400_0000, 32'h6400_000f, PAL_DOM_FAST,
          5'h05, 5'h0e, 5'h02, 5'h05, 5'h0e, 5'h0e, 1'b0, 1'b1},
        '{32'h6400_0010, 32'h6400_0013, PAL_DOM_FAST,
          5'h19, 5'h06, 5'h19, 5'h19, 5'h05, 5'h05, 1'b1, 1'b1},
        '{32'h6400_0014, 32'h6400_0037, PAL_DOM_FAST,
          5'h05, 5'h0e, 5'h02, 5'h05, 5'h0e, 5'h0e, 1'b0, 1'b1},
        '{32'h6400_0804, 32'h6400_0807, PAL_DOM_FAST,
          5'h04, 5'h03, 5'h01, 5'h04, 5'h01, 5'h03, 1'b0, 1'b0},
        '{32'h407f_c000, 32'h407f_efff, PAL_DOM_FLASH,
          5'h03, 5'h03, 5'h02, 5'h03, 5'h02, 5'h03, 1'b0, 1'b0}
    };

    // Inclusive address range test
    function automatic logic pal_in_range(input logic [31:0] a, input logic [31:0] lo,
                                          input logic [31:0] hi);
        pal_in_range = (a >= lo) && (a <= hi);
    endfunction

endpackage

/* File: rtl/pal_lat_table.sv */
// Region decode and core-cycle latency lookup of the access bridge
`timescale 1ns/1ps
module pal_lat_table
    import pal_pkg::*;
(
    input wire logic [31:0] i_addr, // Access address
    input wire logic i_write, // Write access
    input wire pal_size_e i_size, // Access width
    input wire logic [3:0] i_div_a, // Core to fast peripheral clock ratio
    input wire logic [3:0] i_div_b, // Core to slow peripheral clock ratio
    input wire logic [3:0] i_div_f, // Core to flash interface clock ratio
    output logic o_hit, // Address falls in a mapped region
    output logic [4:0] o_idx, // Winning region row
    output logic [9:0] o_lat, // Least latency in core cycles
    output logic o_open // Upper bound open, wait for the peripheral
);
    // Lowest matching row wins so overlapping ranges resolve predictably
    function automatic logic [4:0] first_hit(input logic [PAL_NREG-1:0] v);
        first_hit = 5'h00;
        for (int k = PAL_NREG - 1; k >= 0; k--)
        begin
            if (v[k])
            begin
                first_hit = k[4:0];
            end
        end
    endfunction

    logic [PAL_NREG-1:0] hit_vec;
    pal_region_s sel;
    logic [3:0] dom_div;
    logic faster;
    logic [4:0] eq_cnt;
    logic [4:0] min_cnt;
    logic [4:0] max_cnt;
    logic [4:0] fast_cnt;
    logic [5:0] base_cnt;
    logic [5:0] extra;
    logic [9:0] prod;

    // One comparator pair per row
    genvar g;
    generate
        for (g = 0; g < PAL_NREG; g++)
        begin : g_hit
            assign hit_vec[g] = pal_in_range(i_addr, PAL_TABLE[g].lo, PAL_TABLE[g].hi);
        end
    endgenerate

    assign o_hit = |hit_vec;
    assign o_idx = first_hit(hit_vec);
    assign sel = PAL_TABLE[o_idx];

    // Core-timed rows count directly, others scale by their clock ratio
    assign dom_div = (sel.dom == PAL_DOM_CORE) ? PAL_DIV_EQUAL :
                     (sel.dom == PAL_DOM_FAST) ? i_div_a :
                     (sel.dom == PAL_DOM_SLOW) ? i_div_b : i_div_f;
    assign faster = (dom_div > PAL_DIV_EQUAL);

    assign eq_cnt = i_write ? sel.wr_eq : sel.rd_eq;
    assign min_cnt = i_write ? sel.wr_min : sel.rd_min;
    assign max_cnt = i_write ? sel.wr_max : sel.rd_max;
    assign o_open = i_write ? sel.wr_open : sel.rd_open;

    // Faster core pays the worst sync, at least one extra peripheral cycle; open-ended rows keep the least count
    assign fast_cnt = o_open ? min_cnt :
                      (max_cnt > min_cnt) ? max_cnt : (min_cnt + 5'h01);

    // Width surcharges on the serial data registers
    assign extra = ((o_idx == PAL_REG_SCI) && (i_size == PAL_SZ_HALF)) ? PAL_WIDTH_EXTRA :
                   ((o_idx == PAL_REG_SPI) && (i_size == PAL_SZ_WORD)) ? PAL_WIDTH_EXTRA :
                   6'h00;

    assign base_cnt = {1'b0, (faster ? fast_cnt : eq_cnt)} + extra;
    assign prod = 10'(base_cnt * dom_div);
    assign o_lat = (prod == 10'h000) ? 10'h001 : prod;
endmodule

/* File: rtl/pal_bridge.sv */
// Peripheral access latency bridge: holds each access for its region's timing
//
// Behaviour
// - System-control region accesses take two core cycles, read and write.
// - Converter region: 5 read, 4 write; 2-5 and 2-4 when core faster.
// - Fractional peripheral counts: least bound truncated, most bound rounded up.
// - Sixteen-bit UART register accesses add two cycles to the region base.
// - Eight-bit UART register accesses use exactly the region base latency.
// - Thirty-two-bit SPI data word access adds two cycles to the base.
// - Eight or sixteen-bit SPI data accesses use the base latency only.
// - Flash-interface control port reads take at least 25 cycles, then await completion.
// - Faster core adds at least one peripheral cycle of synchronisation, except on open-ended rows.
// - Writes are non-bufferable: held until the peripheral really takes them.
`timescale 1ns/1ps
module pal_bridge
    import pal_pkg::*;
(
    input wire logic i_clk, // Core clock, 250 MHz
    input wire logic i_nrst, // Asynchronous reset, active low
    input wire logic i_req_valid, // Master offers an access
    input wire pal_req_s i_req, // Address, direction, width, write data
    input wire logic [3:0] i_div_a, // Core/fast peripheral ratio, 1 = equal
    input wire logic [3:0] i_div_b, // Core/slow peripheral ratio, 1 = equal
    input wire logic [3:0] i_div_f, // Core/flash clock ratio, 1 = equal
    input wire logic i_per_ack, // Peripheral finished an open-ended access
    input wire logic [31:0] i_per_rdata, // Peripheral read data
    output logic o_req_ready, // Bridge idle, can take an access
    output pal_rsp_s o_rsp, // Completion pulse with data and error
    output pal_per_s o_per // Access held towards the peripheral
);
    typedef enum logic [1:0] {
        PAL_ST_IDLE = 2'b00,
        PAL_ST_COUNT = 2'b01,
        PAL_ST_WAIT = 2'b10
    } pal_state_e;

    pal_state_e state_ff;
    pal_state_e nxt_state;
    logic [9:0] cnt_ff;
    logic [9:0] nxt_cnt;
    logic [9:0] lat_ff;
    logic [4:0] idx_ff;
    logic open_ff;
    logic err_ff;
    logic ready_ff;
    pal_rsp_s rsp_ff;
    pal_rsp_s nxt_rsp;
    pal_per_s per_ff;
    pal_per_s nxt_per;
    logic hit;
    logic [4:0] idx;
    logic [9:0] lat;
    logic open_end;
    logic take;
    logic cnt_zero;
    logic finish;

    // Latency of the offered access, looked up before it is taken
    pal_lat_table u_table (
        .i_addr (i_req.addr),
        .i_write (i_req.write),
        .i_size (i_req.size),
        .i_div_a (i_div_a),
        .i_div_b (i_div_b),
        .i_div_f (i_div_f),
        .o_hit (hit),
        .o_idx (idx),
        .o_lat (lat),
        .o_open (open_end)
    );

    // Handshake and completion decode
    assign take = i_req_valid && ready_ff;
    assign cnt_zero = (cnt_ff == PAL_CNT_RST);
    // Open-ended rows need the peripheral's own ack after the least count
    assign finish = ((state_ff == PAL_ST_COUNT) && cnt_zero && !open_ff) ||
                    ((state_ff == PAL_ST_WAIT) && i_per_ack);

    // Sequence: idle, count the least latency, then wait if the bound is open
    always_comb
    begin
        nxt_state = state_ff;
        nxt_cnt = cnt_ff;
        case (state_ff)
            PAL_ST_IDLE:
            begin
                if (take)
                begin
                    nxt_state = PAL_ST_COUNT;
                    nxt_cnt = hit ? (lat - 10'h001) : (PAL_UNMAPPED_LAT - 10'h001);
                end
            end
            PAL_ST_COUNT:
            begin
                if (!cnt_zero)
                begin
                    nxt_cnt = cnt_ff - 10'h001;
                end
                else if (open_ff)
                begin
                    nxt_state = PAL_ST_WAIT;
                end
                else
                begin
                    nxt_state = PAL_ST_IDLE;
                end
            end
            PAL_ST_WAIT:
            begin
                if (i_per_ack)
                begin
                    nxt_state = PAL_ST_IDLE;
                end
            end
            default:
            begin
                nxt_state = PAL_ST_IDLE;
            end
        endcase
    end

    // Unmapped addresses never reach a peripheral; they end with an error flag
    always_comb
    begin
        nxt_per = per_ff;
        if (take)
        begin
            nxt_per.req = hit;
            nxt_per.addr = i_req.addr;
            nxt_per.write = i_req.write;
            nxt_per.size = i_req.size;
            nxt_per.wdata = i_req.wdata;
        end
        else if (finish)
        begin
            nxt_per.req = 1'b0;
        end
    end

    // Completion pulse, read data caught as the access ends
    always_comb
    begin
        nxt_rsp.done = finish;
        nxt_rsp.err = finish && err_ff;
        nxt_rsp.rdata = (finish && !per_ff.write && !err_ff) ? i_per_rdata : 32'h0000_0000;
    end

    // State and counter
    always_ff @(posedge i_clk or negedge i_nrst)
    begin
        if (!i_nrst)
        begin
            state_ff <= PAL_ST_IDLE;
            cnt_ff <= PAL_CNT_RST;
        end
        else
        begin
            state_ff <= nxt_state;
            cnt_ff <= nxt_cnt;
        end
    end

    // Attributes of the access in flight
    always_ff @(posedge i_clk or negedge i_nrst)
    begin
        if (!i_nrst)
        begin
            lat_ff <= PAL_CNT_RST;
            idx_ff <= 5'h00;
            open_ff <= 1'b0;
            err_ff <= 1'b0;
        end
        else if (take)
        begin
            lat_ff <= hit ? lat : PAL_UNMAPPED_LAT;
            idx_ff <= idx;
            open_ff <= hit && open_end;
            err_ff <= !hit;
        end
    end

    // Output flops; ready falls on the taking edge so a second request waits
    always_ff @(posedge i_clk or negedge i_nrst)
    begin
        if (!i_nrst)
        begin
            ready_ff <= 1'b0;
            rsp_ff <= '0;
            per_ff <= '0;
        end
        else
        begin
            ready_ff <= (nxt_state == PAL_ST_IDLE);
            rsp_ff <= nxt_rsp;
            per_ff <= nxt_per;
        end
    end

    assign o_req_ready = ready_ff;
    assign o_rsp = rsp_ff;
    assign o_per = per_ff;

    // Cycles since the access was taken, read only by the checks below
    logic [9:0] elapsed_ff;
    always_ff @(posedge i_clk or negedge i_nrst)
    begin
        if (!i_nrst)
        begin
            elapsed_ff <= PAL_CNT_RST;
        end
        else if (take)
        begin
            elapsed_ff <= PAL_CNT_RST;
        end
        else if (state_ff != PAL_ST_IDLE)
        begin
            elapsed_ff <= elapsed_ff + 10'h001;
        end
    end

    default clocking cb @(posedge i_clk); endclocking
    default disable iff (!i_nrst);

    a_sys_two_cycles: assert property (
        (take && hit && idx == PAL_REG_SYS) |-> ##2 (state_ff == PAL_ST_COUNT) ##1 o_rsp.done)
        else $error("system region access did not end after two cycles");
    a_conv_equal: assert property (
        (take && hit && idx == PAL_REG_CONV && i_div_a == PAL_DIV_EQUAL)
        |-> (lat == (i_req.write ? 10'h004 : 10'h005)))
        else $error("converter latency wrong at equal clocks");
    a_fixed_exact: assert property (
        (o_rsp.done && !open_ff) |-> (elapsed_ff == lat_ff))
        else $error("fixed access ended off its table latency");
    a_sci_half_extra: assert property (
        (take && hit && idx == PAL_REG_SCI && i_req.size == PAL_SZ_HALF && i_div_a == 4'h1)
        |-> (lat == (i_req.write ? 10'h006 : 10'h007)))
        else $error("uart halfword surcharge missing");
    a_sci_byte_base: assert property (
        (take && hit && idx == PAL_REG_SCI && i_req.size == PAL_SZ_BYTE && i_div_a == 4'h1)
        |-> (lat == (i_req.write ? 10'h004 : 10'h005)))
        else $error("uart byte access not at base latency");
    a_spi_word_extra: assert property (
        (take && hit && idx == PAL_REG_SPI && i_req.size == PAL_SZ_WORD && i_div_a == 4'h1)
        |-> (lat == (i_req.write ? 10'h006 : 10'h007)))
        else $error("spi word surcharge missing");
    a_spi_narrow_base: assert property (
        (take && hit && idx == PAL_REG_SPI && i_req.size != PAL_SZ_WORD && i_div_a == 4'h1)
        |-> (lat == (i_req.write ? 10'h004 : 10'h005)))
        else $error("spi narrow access not at base latency");
    a_qspi_least: assert property (
        (o_rsp.done && idx_ff == PAL_REG_QCTL && !per_ff.write) |-> (elapsed_ff >= 10'h019))
        else $error("flash control read ended before 25 cycles");
    a_sync_added: assert property (
        (take && hit && idx == PAL_REG_CONV && i_div_a == 4'h2 && !i_req.write)
        |-> (lat == 10'h00a))
        else $error("faster core not charged the synchronised bound");
    a_write_held: assert property (
        (o_per.req && o_per.write && !finish) |=> o_per.req)
        else $error("write released before the peripheral took it");

    c_sys_access: cover property (take && hit && idx == PAL_REG_SYS);
    c_qspi_wait: cover property ((state_ff == PAL_ST_WAIT) ##1 o_rsp.done);
    c_unmapped: cover property (o_rsp.done && o_rsp.err);
    c_slow_faster: cover property (take && hit && i_div_b > 4'h1);
endmodule

/* File: sim/pal_per_model.sv */
// Behavioural model of the peripheral register blocks behind the bridge
`timescale 1ns/1ps
module pal_per_model
    import pal_pkg::*;
(
    input wire logic i_clk, // Core clock
    input wire logic i_nrst, // Asynchronous reset, active low
    input wire pal_per_s i_per, // Access held by the bridge
    input wire logic [7:0] i_ack_dly, // Held cycles before an open access finishes
    output logic o_ack, // Open access finished
    output logic [31:0] o_rdata // Read data
);
    logic [7:0] age_ff;
    logic [31:0] junk_ff;

    // Age of the held access; junk changes every cycle so stale data never looks valid
    always_ff @(posedge i_clk or negedge i_nrst)
    begin
        if (!i_nrst)
        begin
            age_ff <= 8'h00;
            junk_ff <= 32'h1357_9bdf;
        end
        else
        begin
            age_ff <= i_per.req ? age_ff + 8'h01 : 8'h00;
            junk_ff <= {junk_ff[30:0], junk_ff[31] ^ junk_ff[21] ^ junk_ff[1]};
        end
    end

    // Level finish, so an early finish is not lost before the bridge waits for it
    assign o_ack = i_per.req && (age_ff >= i_ack_dly);
    // Data only while a read is held
    assign o_rdata = (i_per.req && !i_per.write) ? (i_per.addr ^ 32'ha5a5_5a5a) : junk_ff;
endmodule

/* File: sim/pal_bridge_bench.sv */
// Self-checking bench of the peripheral access latency bridge
`timescale 1ns/1ps
module pal_bridge_bench;
    import pal_pkg::*;

    typedef struct {
        int take;
        int lat;
        int hi;
        bit open;
        logic err;
        logic wr;
        pal_size_e sz;
        logic [31:0] addr;
        logic [31:0] wdata;
        logic [31:0] rd;
    } pal_note_s;

    // Region table: address, equal-clock and core-faster counts, clock (0 core 1 fast 2 slow 3 flash)
    localparam logic [31:0] T_ADDR [8] = '{32'h4017_1000, 32'h4009_4000, 32'h400e_8000,
        32'h407f_c000, 32'h4001_e400, 32'h4011_8400, 32'h4011_a000, 32'h4000_3000};
    localparam int T_EQ_RD [8] = '{5, 4, 7, 3, 9, 5, 5, 2};
    localparam int T_EQ_WR [8] = '{4, 3, 4, 3, 8, 4, 4, 2};
    localparam int T_MX_RD [8] = '{5, 4, 7, 3, 8, 5, 5, 2};
    localparam int T_MX_WR [8] = '{4, 3, 4, 3, 8, 4, 4, 2};
    localparam int T_DOM [8] = '{1, 2, 2, 3, 2, 1, 1, 0};

    logic clk;
    logic nrst;
    logic valid;
    pal_req_s req;
    logic [3:0] div_a;
    logic [3:0] div_b;
    logic [3:0] div_f;
    logic per_ack;
    logic [31:0] per_rdata;
    logic ready;
    pal_rsp_s rsp;
    pal_per_s per;
    logic [7:0] ack_dly;
    pal_note_s notes[$];
    int cyc;
    int held;
    int n_fail;
    int n_tests;

    pal_bridge pal_bridge_inst (.i_clk(clk), .i_nrst(nrst), .i_req_valid(valid), .i_req(req),
        .i_div_a(div_a), .i_div_b(div_b), .i_div_f(div_f), .i_per_ack(per_ack),
        .i_per_rdata(per_rdata), .o_req_ready(ready), .o_rsp(rsp), .o_per(per));

    pal_per_model pal_per_model_inst (.i_clk(clk), .i_nrst(nrst), .i_per(per),
        .i_ack_dly(ack_dly), .o_ack(per_ack), .o_rdata(per_rdata));

    initial
    begin
        clk = 1'b0;
        forever #2 clk = ~clk;
    end

    task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string what);
        n_tests++;
        if (seen !== exp)
        begin
            n_fail++;
            $display("Error at %0t: %s seen %h expected %h", $time, what, seen, exp);
        end
    endtask

    task automatic wrap_up;
        $display("Checks %0d, mismatches %0d", n_tests, n_fail);
        if (n_fail == 0 && n_tests > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask

    // Offer one access, hold it until taken, then note what must come back
    task automatic acc(input logic [31:0] addr, input logic wr, input pal_size_e sz,
                       input int lat, input bit open, input logic err);
        pal_note_s n;
        valid = 1'b1;
        req.addr = addr;
        req.write = wr;
        req.size = sz;
        req.wdata = $urandom;
        for (int k = 0; k < 3000 && ready !== 1'b1; k++)
        begin
            @(posedge clk);
            #1;
        end
        // A wait that runs out counts against the run
        check({31'h0, ready}, 32'h1, "ready before request");
        @(posedge clk);
        #1;
        n.take = cyc;
        n.sz = sz;
        n.open = open;
        n.lat = (open && ack_dly > lat) ? int'(ack_dly) : lat;
        n.hi = open ? n.lat + 4 : lat;
        n.err = err;
        n.wr = wr;
        n.addr = addr;
        n.wdata = req.wdata;
        n.rd = (wr || err) ? 32'h0000_0000 : (addr ^ 32'ha5a5_5a5a);
        notes.push_back(n);
    endtask

    // Let the last access finish before settings change
    task automatic idle;
        valid = 1'b0;
        for (int k = 0; k < 3000 && ready !== 1'b1; k++)
        begin
            @(posedge clk);
            #1;
        end
        check({31'h0, ready}, 32'h1, "ready when idle");
        @(posedge clk);
        #1;
    endtask

    // Cycle count and hang guard
    always @(posedge clk)
    begin
        cyc <= cyc + 1;
        if (cyc >= 20000)
        begin
            n_fail++;
            $display("Error at %0t: run did not finish", $time);
            wrap_up;
        end
    end

    // Watcher: takes the oldest note whenever a completion shows
    always @(negedge clk)
    begin
        pal_note_s n;
        int lat;
        if (nrst && per.req === 1'b1 && held == 0 && notes.size() > 0)
        begin
            check(per.addr, notes[0].addr, "forwarded address");
            check({31'h0, per.write}, {31'h0, notes[0].wr}, "forwarded direction");
            check(per.wdata, notes[0].wdata, "forwarded write data");
            check({30'h0, per.size}, {30'h0, notes[0].sz}, "forwarded width");
        end
        if (nrst && per.req === 1'b1)
            held++;
        if (nrst && rsp.done === 1'b1)
        begin
            n = notes.pop_front();
            lat = cyc - n.take;
            if (n.open)
                check({31'h0, lat >= n.lat && lat <= n.hi}, 32'h1, "open latency");
            else
                check(32'(lat), 32'(n.lat), "latency");
            check({31'h0, rsp.err}, {31'h0, n.err}, "error flag");
            check(rsp.rdata, n.rd, "read data");
            check({31'h0, ready}, 32'h1, "ready with answer");
            check(32'(held), n.err ? 32'h0 : 32'(lat), "held cycles");
            held = 0;
        end
    end

    initial
    begin
        int ratio;
        int cnt;
        nrst = 1'b0;
        valid = 1'b0;
        req = '0;
        div_a = 4'h1;
        div_b = 4'h1;
        div_f = 4'h1;
        ack_dly = 8'h01;
        cyc = 0;
        held = 0;
        n_fail = 0;
        n_tests = 0;
        void'($urandom(91977));
        repeat (20) @(posedge clk);
        #1;
        check({31'h0, ready}, 32'h0, "ready in reset");
        nrst = 1'b1;
        // Pass 0 equal clocks, pass 1 core faster; every width, read and write
        for (int p = 0; p < 2; p++)
        begin
            idle;
            div_a = p ? 4'(2 + $urandom % 3) : 4'h1;
            div_b = p ? 4'(2 + $urandom % 3) : 4'h1;
            div_f = p ? 4'(2 + $urandom % 3) : 4'h1;
            for (int r = 0; r < 8; r++)
                for (int s = 0; s < 3; s++)
                    for (int w = 0; w < 2; w++)
                    begin
                        ratio = (T_DOM[r] == 1) ? div_a : (T_DOM[r] == 2) ? div_b :
                                (T_DOM[r] == 3) ? div_f : 1;
                        cnt = p ? (w ? T_MX_WR[r] : T_MX_RD[r]) : (w ? T_EQ_WR[r] : T_EQ_RD[r]);
                        if ((r == 5 && s == 1) || (r == 6 && s == 2))
                            cnt += 2;
                        acc(T_ADDR[r] + (($urandom % 64) << 2), w[0], pal_size_e'(s),
                            cnt * ratio, 1'b0, 1'b0);
                    end
            $display("Region table pass %0d done", p);
        end
        // Flash-interface control port: prompt and slow finish, then an equal-clock write
        idle;
        div_a = 4'h3;
        acc(32'h6400_0010, 1'b0, PAL_SZ_WORD, 75, 1'b1, 1'b0);
        idle;
        ack_dly = 8'd90;
        acc(32'h6400_0010, 1'b0, PAL_SZ_WORD, 75, 1'b1, 1'b0);
        idle;
        ack_dly = 8'h01;
        div_a = 4'h1;
        acc(32'h6400_0010, 1'b1, PAL_SZ_WORD, 6, 1'b1, 1'b0);
        idle;
        $display("Open-ended port test done");
        // Unmapped places back to back after a good access
        acc(32'h4000_6ffc, 1'b0, PAL_SZ_WORD, 2, 1'b0, 1'b0);
        acc(32'h4000_7000, 1'b0, PAL_SZ_WORD, 2, 1'b0, 1'b1);
        acc(32'h5000_0000, 1'b1, PAL_SZ_BYTE, 2, 1'b0, 1'b1);
        idle;
        repeat (5) @(posedge clk);
        #1;
        check(32'(notes.size()), 32'h0, "answers outstanding");
        $display("Unmapped test done");
        wrap_up;
    end
endmodule
